// File: core/arith_status_pkg.sv
package arith_status_pkg;

  // ****************************************************************
  // Widths and data-memory indices
  // ****************************************************************
  localparam int          IDX_W        = 9;
  localparam int          DATA_W       = 8;
  localparam int          UPLATCH_W    = 5;
  localparam int          NUM_ARITH    = 3;
  localparam int          BANK_LSB     = 7;

  // Register core_arith_flags is mirrored at these four indices
  localparam logic [8:0]  STATUS_IDX_B0 = 9'h003;
  localparam logic [8:0]  STATUS_IDX_B1 = 9'h083;
  localparam logic [8:0]  STATUS_IDX_B2 = 9'h103;
  localparam logic [8:0]  STATUS_IDX_B3 = 9'h183;
  // Low seven index bits shared by every mirror of a common register
  localparam logic [6:0]  STATUS_LO    = 7'h03;
  localparam logic [6:0]  UPLATCH_LO   = 7'h0A;
  localparam logic [8:0]  PORTA_IDX    = 9'h005;
  localparam logic [8:0]  TRISA_IDX    = 9'h085;

  // ****************************************************************
  // Status field positions, masks and reset values
  // ****************************************************************
  localparam int          IND_BANK_BIT = 7;
  localparam int          DIR_HI_BIT   = 6;
  localparam int          DIR_LO_BIT   = 5;
  localparam int          WDT_EXP_BIT  = 4;
  localparam int          PWR_DN_BIT   = 3;
  localparam int          ZERO_BIT     = 2;
  localparam int          HALF_BIT     = 1;
  localparam int          CARRY_BIT    = 0;
  localparam int          PIN5_BIT     = 5;

  localparam logic [7:0]  BANK_MASK    = 8'hE0;
  localparam logic [7:0]  ARITH_MASK   = 8'h07;
  localparam logic [7:0]  SOFT_WR_MASK = 8'hE7;
  localparam logic [7:0]  PIN5_MASK    = 8'h20;
  localparam logic [7:0]  STATUS_RST   = 8'h18;
  localparam logic [4:0]  UPLATCH_RST  = 5'h00;
  localparam logic [4:0]  PC_HI_RST    = 5'h00;
  localparam logic [7:0]  TRISA_RST    = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [8:0]  ONE_9        = 9'h001;
  localparam logic [4:0]  ONE_5        = 5'h01;

  // ****************************************************************
  // AHB-Lite
  // ****************************************************************
  localparam int          HADDR_W      = 32;
  localparam int          HDATA_W      = 32;
  localparam int          IDX_LSB      = 2;
  localparam int          IDX_MSB      = 10;
  localparam logic        HRESP_OKAY   = 1'b0;
  localparam logic [23:0] HRDATA_PAD   = 24'h000000;
  localparam logic [31:0] HRDATA_RST   = 32'h00000000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_MOVE  = 3'b001,
    OP_ADD   = 3'b010,
    OP_SUB   = 3'b011,
    OP_AND   = 3'b100,
    OP_OR    = 3'b101,
    OP_XOR   = 3'b110,
    OP_CLEAR = 3'b111
  } alu_op_type;

  typedef struct packed {
    alu_op_type  op;
    logic [7:0]  opnd_a;
    logic [7:0]  opnd_b;
    logic        dest_wr;
    logic [8:0]  dest_idx;
    logic        pc_load;
    logic [8:0]  rd_idx;
  } core_req_type;

  typedef struct packed {
    logic wdt_clear;
    logic sleep_enter;
    logic wdt_expire;
  } pmu_evt_type;

  // Flag order in flags and affect: {zero, half, carry}
  typedef struct packed {
    logic [7:0] result;
    logic [2:0] flags;
    logic [2:0] affect;
  } flag_out_type;

  typedef struct packed {
    logic [7:0]  status;
    logic [4:0]  uplatch;
    logic [4:0]  pc_hi;
    logic [7:0]  trisa;
    logic [31:0] hrdata;
    logic        dp_write;
    logic [8:0]  dp_idx;
    logic [7:0]  core_rd;
    logic [7:0]  result;
  } arith_state_type;

  localparam arith_state_type STATE_RST = '{
    status:   STATUS_RST,
    uplatch:  UPLATCH_RST,
    pc_hi:    PC_HI_RST,
    trisa:    TRISA_RST,
    hrdata:   HRDATA_RST,
    dp_write: 1'b0,
    dp_idx:   9'h000,
    core_rd:  BYTE_ZERO,
    result:   BYTE_ZERO
  };

endpackage

// File: core/flag_logic.sv
`timescale 1ns/100ps
module flag_logic
  import arith_status_pkg::*;
(
  input  wire alu_op_type   op,
  input  wire logic [7:0]   opnd_a,
  input  wire logic [7:0]   opnd_b,
  input  wire logic         carry_in,
  output flag_out_type      fout
);

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res;

  always_comb begin
    sum         = {1'b0, opnd_a} + {1'b0, opnd_b};
    nib         = {1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]};
    res         = BYTE_ZERO;
    fout.affect = 3'b000;
    fout.flags  = {1'b0, carry_in, carry_in};
    case (op)
      OP_MOVE: begin
        res = opnd_a;
      end
      OP_ADD: begin
        res         = sum[7:0];
        fout.affect = 3'b111;
        fout.flags  = {1'b0, nib[4], sum[8]};
      end
      OP_SUB: begin
        // Carry out of a + ~b + 1: high means no borrow, low means borrow
        sum         = {1'b0, opnd_a} + {1'b0, ~opnd_b} + ONE_9;
        nib         = {1'b0, opnd_a[3:0]} + {1'b0, ~opnd_b[3:0]} + ONE_5;
        res         = sum[7:0];
        fout.affect = 3'b111;
        fout.flags  = {1'b0, nib[4], sum[8]};
      end
      OP_AND: begin
        res         = opnd_a & opnd_b;
        fout.affect = 3'b100;
      end
      OP_OR: begin
        res         = opnd_a | opnd_b;
        fout.affect = 3'b100;
      end
      OP_XOR: begin
        res         = opnd_a ^ opnd_b;
        fout.affect = 3'b100;
      end
      OP_CLEAR: begin
        res         = BYTE_ZERO;
        fout.affect = 3'b100;
      end
      default: begin
        res = BYTE_ZERO;
      end
    endcase
    fout.result   = res;
    fout.flags[2] = (res == BYTE_ZERO);
  end

endmodule

// File: core/arith_status_regs.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
module arith_status_regs
  import arith_status_pkg::*;
(
  input  wire logic                CORE_CLK,
  input  wire logic                RESETN,
  // AHB-Lite slave
  input  wire logic                HSEL,
  input  wire logic [HADDR_W-1:0]  HADDR,
  input  wire logic [1:0]          HTRANS,
  input  wire logic                HWRITE,
  input  wire logic [2:0]          HSIZE,
  input  wire logic [HDATA_W-1:0]  HWDATA,
  input  wire logic                HREADY,
  output logic [HDATA_W-1:0]       HRDATA,
  output logic                     HREADYOUT,
  output logic                     HRESP,
  // Core side
  input  wire core_req_type        CORE_REQ,
  input  wire pmu_evt_type         PMU_EVT,
  input  wire logic                PORT_A_PIN_FIVE,
  output logic [7:0]               STATUS_OUT,
  output logic [7:0]               ALU_RESULT,
  output logic [7:0]               CORE_RDATA,
  output logic [4:0]               PC_UPPER,
  output logic                     INDIRECT_BANK_SELECT,
  output logic [1:0]               DIRECT_BANK_SELECT,
  output logic                     PORT_A_PIN_FIVE_OE
);

  arith_state_type s_q;
  arith_state_type s_d;
  flag_out_type    fout;
  logic            addr_phase;
  logic            addr_ok;
  logic [8:0]      haddr_idx;
  logic [7:0]      wr_mask;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic is_status(input logic [8:0] idx);
    is_status = (idx[BANK_LSB-1:0] == STATUS_LO);
  endfunction

  function automatic logic is_uplatch(input logic [8:0] idx);
    is_uplatch = (idx[BANK_LSB-1:0] == UPLATCH_LO);
  endfunction

  function automatic logic [7:0] read_reg(input arith_state_type st,
                                          input logic [8:0]      idx,
                                          input logic            pin5);
    if (is_status(idx)) begin
      read_reg = st.status;
    end else if (is_uplatch(idx)) begin
      read_reg = {3'b000, st.uplatch};
    end else if (idx == TRISA_IDX) begin
      read_reg = st.trisa | PIN5_MASK;
    end else if (idx == PORTA_IDX) begin
      read_reg = PIN5_MASK & {DATA_W{pin5}};
    end else begin
      read_reg = BYTE_ZERO;
    end
  endfunction

  // ****************************************************************
  // Flag logic
  // ****************************************************************
  flag_logic u_flag_logic (
    .op       (CORE_REQ.op),
    .opnd_a   (CORE_REQ.opnd_a),
    .opnd_b   (CORE_REQ.opnd_b),
    .carry_in (s_q.status[CARRY_BIT]),
    .fout     (fout)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d        = s_q;
    haddr_idx  = HADDR[IDX_MSB:IDX_LSB];
    addr_ok    = (HADDR[HADDR_W-1:IDX_MSB+1] == '0);
    addr_phase = HSEL & HREADY & HTRANS[1];
    wr_mask    = SOFT_WR_MASK;

    // Bus data phase write; a bus write never reaches the reset-cause flags
    if (s_q.dp_write) begin
      if (is_status(s_q.dp_idx)) begin
        s_d.status = (s_d.status & ~SOFT_WR_MASK) | (HWDATA[7:0] & SOFT_WR_MASK);
      end else if (is_uplatch(s_q.dp_idx)) begin
        s_d.uplatch = HWDATA[UPLATCH_W-1:0];
      end else if (s_q.dp_idx == TRISA_IDX) begin
        s_d.trisa = HWDATA[7:0] | PIN5_MASK;
      end
    end

    // Instruction write lands after the bus write, so the core wins a collision
    if (CORE_REQ.dest_wr && (CORE_REQ.op != OP_NONE)) begin
      if (is_status(CORE_REQ.dest_idx)) begin
        if (fout.affect != 3'b000) begin
          wr_mask = BANK_MASK;
        end
        // Reset-cause bits are outside both masks
        s_d.status = (s_d.status & ~wr_mask) | (fout.result & wr_mask);
      end else if (is_uplatch(CORE_REQ.dest_idx)) begin
        s_d.uplatch = fout.result[UPLATCH_W-1:0];
      end else if (CORE_REQ.dest_idx == TRISA_IDX) begin
        s_d.trisa = fout.result | PIN5_MASK;
      end
    end

    // Flags from the flag logic override whatever the destination write left
    for (int i = 0; i < NUM_ARITH; i++) begin
      if (fout.affect[i]) begin
        s_d.status[CARRY_BIT+i] = fout.flags[i];
      end
    end
    if (CORE_REQ.op != OP_NONE) begin
      s_d.result = fout.result;
    end

    // Reset-cause flags move only on power-management events
    if (PMU_EVT.wdt_clear) begin
      s_d.status[WDT_EXP_BIT] = 1'b1;
      s_d.status[PWR_DN_BIT]  = 1'b1;
    end
    if (PMU_EVT.sleep_enter) begin
      s_d.status[WDT_EXP_BIT] = 1'b1;
      s_d.status[PWR_DN_BIT]  = 1'b0;
    end
    // Expiry is last so it is never masked by a clear in the same cycle
    if (PMU_EVT.wdt_expire) begin
      s_d.status[WDT_EXP_BIT] = 1'b0;
    end

    // Upper program counter is only ever fed from the latch
    if (CORE_REQ.pc_load) begin
      s_d.pc_hi = s_q.uplatch;
    end

    // Reads see this cycle's writes so back-to-back write then read is coherent
    s_d.core_rd  = read_reg(s_d, CORE_REQ.rd_idx, PORT_A_PIN_FIVE);
    s_d.dp_write = addr_phase & HWRITE & addr_ok;
    s_d.dp_idx   = haddr_idx;
    if (addr_phase && !HWRITE) begin
      s_d.hrdata = addr_ok ? {HRDATA_PAD, read_reg(s_d, haddr_idx, PORT_A_PIN_FIVE)}
                           : HRDATA_RST;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign HRDATA               = s_q.hrdata;
  assign HREADYOUT            = 1'b1;
  assign HRESP                = HRESP_OKAY;
  assign STATUS_OUT           = s_q.status;
  assign ALU_RESULT           = s_q.result;
  assign CORE_RDATA           = s_q.core_rd;
  assign PC_UPPER             = s_q.pc_hi;
  // High selects banks 2 and 3 for indirect accesses
  assign INDIRECT_BANK_SELECT = s_q.status[IND_BANK_BIT];
  assign DIRECT_BANK_SELECT   = {s_q.status[DIR_HI_BIT], s_q.status[DIR_LO_BIT]};
  assign PORT_A_PIN_FIVE_OE   = 1'b0;

endmodule

// File: bench/arith_status_regs_assertions.sv
`timescale 1ns/100ps
module arith_status_chk
  import arith_status_pkg::*;
(
  input wire logic         CORE_CLK,
  input wire logic         RESETN,
  input wire core_req_type CORE_REQ,
  input wire pmu_evt_type  PMU_EVT,
  input wire logic [7:0]   STATUS_OUT,
  input wire logic [4:0]   PC_UPPER,
  input wire logic         INDIRECT_BANK_SELECT,
  input wire logic [1:0]   DIRECT_BANK_SELECT,
  input wire logic         PORT_A_PIN_FIVE_OE
);
  logic [8:0] sub_sum;
  logic [4:0] sub_half;
  logic [8:0] add_sum;
  logic [4:0] add_half;
  logic       to_st;
  assign sub_sum  = {1'b0, CORE_REQ.opnd_a} + {1'b0, ~CORE_REQ.opnd_b} + 9'h001;
  assign sub_half = {1'b0, CORE_REQ.opnd_a[3:0]} + {1'b0, ~CORE_REQ.opnd_b[3:0]} + 5'h01;
  assign add_sum  = {1'b0, CORE_REQ.opnd_a} + {1'b0, CORE_REQ.opnd_b};
  assign add_half = {1'b0, CORE_REQ.opnd_a[3:0]} + {1'b0, CORE_REQ.opnd_b[3:0]};
  assign to_st    = CORE_REQ.dest_wr && (CORE_REQ.dest_idx[6:0] == STATUS_LO);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  sub_flags_a: assert property (CORE_REQ.op == OP_SUB |=>
    STATUS_OUT[2:0] == $past({sub_sum[7:0] == 8'h00, sub_half[4], sub_sum[8]}))
    else $error("subtract flags wrong");
  add_status_a: assert property (to_st && CORE_REQ.op == OP_ADD |=>
    STATUS_OUT[2:0] == $past({add_sum[7:0] == 8'h00, add_half[4], add_sum[8]})
    && STATUS_OUT[7:5] == $past(add_sum[7:5])) else $error("add to status wrong");
  clear_status_a: assert property (to_st && CORE_REQ.op == OP_CLEAR && PMU_EVT == '0 |=>
    STATUS_OUT == (($past(STATUS_OUT) & 8'h1B) | 8'h04)) else $error("clear status wrong");
  cause_hold_a: assert property (PMU_EVT == '0 |=> $stable(STATUS_OUT[4:3]))
    else $error("reset cause flags changed");
  pc_hold_a: assert property (!CORE_REQ.pc_load |=> $stable(PC_UPPER))
    else $error("upper pc changed without load");
  pin_input_a: assert property (PORT_A_PIN_FIVE_OE == 1'b0)
    else $error("pin five driven");
  ind_bank_a: assert property (INDIRECT_BANK_SELECT == STATUS_OUT[IND_BANK_BIT])
    else $error("indirect select mismatch");
  dir_bank_a: assert property (DIRECT_BANK_SELECT == STATUS_OUT[6:5])
    else $error("direct select mismatch");
  cover property (to_st && CORE_REQ.op == OP_CLEAR);
  cover property (CORE_REQ.op == OP_SUB);
  cover property (CORE_REQ.pc_load);
  cover property (PMU_EVT.wdt_expire);
endmodule
bind arith_status_regs arith_status_chk chk_i (.CORE_CLK, .RESETN, .CORE_REQ, .PMU_EVT,
  .STATUS_OUT, .PC_UPPER, .INDIRECT_BANK_SELECT, .DIRECT_BANK_SELECT, .PORT_A_PIN_FIVE_OE);

// File: bench/core_model.sv
`timescale 1ns/100ps
module core_model
  import arith_status_pkg::*;
(
  input  wire logic   CORE_CLK,
  output core_req_type req,
  output pmu_evt_type  pmu
);
  initial begin
    req = '0;
    pmu = '0;
  end
  // One instruction held for one cycle; the idle edge after keeps pulses single
  task automatic issue(input alu_op_type op, input logic [7:0] a, input logic [7:0] b,
                       input logic dw, input logic pcl);
    req <= '{op: op, opnd_a: a, opnd_b: b, dest_wr: dw, dest_idx: STATUS_IDX_B2,
             pc_load: pcl, rd_idx: STATUS_IDX_B1};
    @(posedge CORE_CLK);
    req <= '{op: OP_NONE, opnd_a: 8'h00, opnd_b: 8'h00, dest_wr: 1'b0, dest_idx: 9'h000,
             pc_load: 1'b0, rd_idx: STATUS_IDX_B1};
    @(posedge CORE_CLK);
  endtask
  // Power-management events: one-cycle pulse, then an idle edge
  task automatic pulse(input pmu_evt_type ev);
    pmu <= ev;
    @(posedge CORE_CLK);
    pmu <= '0;
    @(posedge CORE_CLK);
  endtask
endmodule

// File: bench/arith_status_regs_tb_top.sv
`timescale 1ns/100ps
module arith_status_regs_tb_top;
  import arith_status_pkg::*;
  logic         clk, resetn, hsel, hwrite, hready, hresp, ind, oe;
  logic [31:0]  haddr, hwdata, hrdata;
  logic [1:0]   htrans, dir;
  logic [7:0]   st, alu, crd;
  logic [4:0]   pcu;
  core_req_type req;
  pmu_evt_type  pmu;
  int           failures, n_checks;
  logic [31:0]  mir[3] = '{32'h00C, 32'h40C, 32'h60C};
  logic [7:0]   sub_t[3][3] = '{'{8'h10, 8'h01, 8'h01}, '{8'h01, 8'h02, 8'h00},
                                '{8'h05, 8'h05, 8'h07}};

  arith_status_regs uut (.CORE_CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .CORE_REQ(req), .PMU_EVT(pmu),
    .PORT_A_PIN_FIVE(1'b1), .STATUS_OUT(st), .ALU_RESULT(alu), .CORE_RDATA(crd),
    .PC_UPPER(pcu), .INDIRECT_BANK_SELECT(ind), .DIRECT_BANK_SELECT(dir),
    .PORT_A_PIN_FIVE_OE(oe));
  core_model core_i (.CORE_CLK(clk), .req(req), .pmu(pmu));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask

  task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] wd,
                     output logic [7:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      failures++;
      complete_run();
    end
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 40);
    rd = hrdata[7:0];
    if (hready !== 1'b1) begin
      failures++;
      complete_run();
    end
    chk("bus response", 8'h00, {7'h00, hresp});
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(a, 1'b1, d, x);
  endtask

  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [7:0] exp);
    logic [7:0] x;
    bus(a, 1'b0, 8'h00, x);
    chk(nm, exp, x);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    complete_run();
  end

  initial begin
    failures = 0;
    n_checks = 0;
    resetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd_chk("status reset", 32'h00C, 8'h18);
    wr(32'h20C, 8'hE5);
    foreach (mir[i]) rd_chk("status mirror", mir[i], 8'hFD);
    chk("bank selects", 8'h07, {5'h00, ind, dir});
    rd_chk("unmapped", 32'h004, 8'h00);
    $display("test mirrors done");
    wr(32'h00C, 8'hE3);
    core_i.issue(OP_CLEAR, 8'h00, 8'h00, 1'b1, 1'b0);
    chk("clear status", 8'h1F, st);
    chk("core read status", 8'h1F, crd);
    core_i.issue(OP_ADD, 8'hF0, 8'h20, 1'b1, 1'b0);
    chk("add to status", 8'h19, st);
    foreach (sub_t[i]) begin
      core_i.issue(OP_SUB, sub_t[i][0], sub_t[i][1], 1'b0, 1'b0);
      chk("sub flags", sub_t[i][2], {5'h00, st[2:0]});
      chk("sub result", sub_t[i][0] - sub_t[i][1], alu);
    end
    core_i.issue(OP_MOVE, 8'h00, 8'h00, 1'b1, 1'b0);
    chk("move to status", 8'h18, st);
    // Event pulses are {wdt_clear, sleep_enter, wdt_expire}
    core_i.pulse(3'b010);
    chk("sleep flags", 8'h10, st);
    core_i.issue(OP_MOVE, 8'hFF, 8'h00, 1'b1, 1'b0);
    chk("move keeps cause", 8'hF7, st);
    core_i.pulse(3'b101);
    chk("expire over clear", 8'hEF, st);
    core_i.pulse(3'b100);
    chk("wdt clear flags", 8'hFF, st);
    $display("test flags done");
    wr(32'h628, 8'h15);
    rd_chk("latch mirror", 32'h028, 8'h15);
    core_i.issue(OP_NONE, 8'h00, 8'h00, 1'b0, 1'b1);
    chk("upper pc", 8'h15, {3'b000, pcu});
    wr(32'h214, 8'h00);
    rd_chk("pin five dir", 32'h214, 8'h20);
    rd_chk("pin five in", 32'h014, 8'h20);
    chk("pin five oe", 8'h00, {7'h00, oe});
    $display("test latch and pin done");
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("status after reset", 8'h18, st);
    chk("upper pc after reset", 8'h00, {3'b000, pcu});
    rd_chk("latch after reset", 32'h228, 8'h00);
    $display("test reset done");
    complete_run();
  end
endmodule
